/* File: pkg/tws_pkg.sv */
// Constants, register map and state codes of the two-wire slave interface.
// Assumes an AHB-Lite register bus with 32-bit data and one slave.
package tws_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTL0 = 8'h00;
	localparam logic [7:0] OFS_CTL1 = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0c;
	localparam logic [7:0] OFS_IEN  = 8'h10;

	// serial_control_zero fields
	localparam int BIT_EN       = 0;
	localparam int POS_MODE     = 1;
	localparam logic [2:0] MODE_TWO_WIRE = 3'h6;

	// serial_control_one fields
	localparam int BIT_PEND  = 0;
	localparam int BIT_BYTE_DONE       = 1;
	localparam int BIT_ACK_RECEIVED    = 2;
	localparam int BIT_ACK_TO_SEND     = 3;
	localparam int BIT_TRANSMIT_SELECT = 4;
	localparam int BIT_RW    = 5;
	localparam int BIT_MATCH = 6;
	localparam int BIT_BUSY  = 7;

	// Values after reset
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [6:0] RST_ADDR = 7'h00;
	localparam logic [2:0] RST_MODE = 3'h0;

	// Index of the last bit of a byte, counted from zero
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Width of the pin synchroniser, one bit per bus pin
	localparam int SYNC_STAGES = 2;

	typedef enum logic [10:0] {
		ST_IDLE    = 11'b000_0000_0001,
		ST_ADDR    = 11'b000_0000_0010,
		ST_ACK_SET = 11'b000_0000_0100,
		ST_ACK_END = 11'b000_0000_1000,
		ST_STRETCH = 11'b000_0001_0000,
		ST_RX      = 11'b000_0010_0000,
		ST_TX      = 11'b000_0100_0000,
		ST_TX_REL  = 11'b000_1000_0000,
		ST_TX_CHK  = 11'b001_0000_0000,
		ST_TX_END  = 11'b010_0000_0000,
		ST_IGNORE  = 11'b100_0000_0000
	} tws_state_t;

endpackage

/* File: logic/tws_pin_sync.sv */
// Two-flop synchroniser for bus pins, plus a delayed copy for edge finding.
// Assumes pins are asynchronous to CLK.
`timescale 1ns/1ns
module tws_pin_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Pins in, synchronised levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q,
	output logic      [W-1:0] q_prev
);

	logic [W-1:0] meta_q;

	// Refuse an empty pin group at elaboration
	if (W < 1) begin : g_bad_width
		$error("tws_pin_sync: W must be at least 1");
	end

	// Idle bus is high, so reset to ones avoids a false edge
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '1;
			q      <= '1;
			q_prev <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
			q_prev <= q;
		end
	end

endmodule

/* File: logic/tws_slave.sv */
// Two-wire slave interface with AHB-Lite register access.
// Assumes an external master drives SCL; open-drain pins resolved outside.
`timescale 1ns/1ns
module tws_slave (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Serial clock pin
	input  wire logic        SCL_I,
	output logic             SCL_O,
	output logic             SCL_OE,
	// Serial data pin
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE,
	// Interrupt request
	output logic             IRQ
);

	typedef struct packed {
		tws_pkg::tws_state_t st;
		logic [2:0]          cnt;
		logic [7:0]          shreg;
		logic                ack_drv;
		logic                en;
		logic [2:0]          mode;
		logic [6:0]          own_addr;
		logic [7:0]          data;
		logic                ien;
		logic                busy;
		logic                match;
		logic                rw;
		logic                transmit_select_bit;
		logic                ack_to_send_bit;
		logic                ack_received_flag;
		logic                byte_done_flag;
		logic                pend;
		logic                ph_wr;
		logic [7:0]          ph_ofs;
		logic                sda_oe;
		logic                scl_oe;
		logic                irq;
		logic [31:0]         hrdata;
	} tws_regs_t;

	tws_regs_t r_q;
	tws_regs_t r_d;

	logic [1:0] pin_s;
	logic [1:0] pin_p;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	tws_pin_sync #(
		.W(tws_pkg::SYNC_STAGES)
	) u_sync (
		.clk    (CLK),
		.rst    (RST),
		.d      ({SCL_I, SDA_I}),
		.q      (pin_s),
		.q_prev (pin_p)
	);

	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic active;

	assign sda      = pin_s[0];
	assign scl_rise = pin_s[1] & ~pin_p[1];
	assign scl_fall = ~pin_s[1] & pin_p[1];
	assign start_det = pin_s[1] & pin_p[1] & pin_p[0] & ~pin_s[0];
	assign stop_det  = pin_s[1] & pin_p[1] & ~pin_p[0] & pin_s[0];
	assign active = r_q.en & (r_q.mode == tws_pkg::MODE_TWO_WIRE);

	////////////////////////////////////////////////////////////////////////
	// Register read mux

	function automatic logic [31:0] rd_mux(input tws_regs_t s, input logic [7:0] ofs);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (ofs == tws_pkg::OFS_CTL0) begin
			v[tws_pkg::BIT_EN]                      = s.en;
			v[tws_pkg::POS_MODE +: 3]               = s.mode;
		end else if (ofs == tws_pkg::OFS_CTL1) begin
			v[tws_pkg::BIT_PEND]  = s.pend;
			v[tws_pkg::BIT_BYTE_DONE]       = s.byte_done_flag;
			v[tws_pkg::BIT_ACK_RECEIVED]    = s.ack_received_flag;
			v[tws_pkg::BIT_ACK_TO_SEND]     = s.ack_to_send_bit;
			v[tws_pkg::BIT_TRANSMIT_SELECT] = s.transmit_select_bit;
			v[tws_pkg::BIT_RW]    = s.rw;
			v[tws_pkg::BIT_MATCH] = s.match;
			v[tws_pkg::BIT_BUSY]  = s.busy;
		end else if (ofs == tws_pkg::OFS_ADDR) begin
			v[7:1] = s.own_addr;
		end else if (ofs == tws_pkg::OFS_DATA) begin
			v[7:0] = s.data;
		end else if (ofs == tws_pkg::OFS_IEN) begin
			v[0] = s.ien;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	logic addr_take;
	logic data_rd;
	logic data_wr;
	logic [7:0] ofs;

	always_comb begin
		r_d = r_q;
		ofs = HADDR[7:0];
		addr_take = HSEL & HTRANS[1] & HREADY;
		data_rd = addr_take & ~HWRITE & (ofs == tws_pkg::OFS_DATA);
		data_wr = r_q.ph_wr & (r_q.ph_ofs == tws_pkg::OFS_DATA);

		// Bus address phase; zero wait states
		r_d.ph_wr  = addr_take & HWRITE;
		r_d.ph_ofs = ofs;
		if (addr_take & ~HWRITE) begin
			r_d.hrdata = rd_mux(r_q, ofs);
		end

		// Bus data phase writes
		if (r_q.ph_wr) begin
			if (r_q.ph_ofs == tws_pkg::OFS_CTL0) begin
				r_d.en   = HWDATA[tws_pkg::BIT_EN];
				r_d.mode = HWDATA[tws_pkg::POS_MODE +: 3];
			end else if (r_q.ph_ofs == tws_pkg::OFS_CTL1) begin
				r_d.transmit_select_bit = HWDATA[tws_pkg::BIT_TRANSMIT_SELECT];
				r_d.ack_to_send_bit     = HWDATA[tws_pkg::BIT_ACK_TO_SEND];
				if (HWDATA[tws_pkg::BIT_PEND]) begin
					r_d.pend = 1'b0;
				end
			end else if (r_q.ph_ofs == tws_pkg::OFS_ADDR) begin
				r_d.own_addr = HWDATA[7:1];
			end else if (r_q.ph_ofs == tws_pkg::OFS_DATA) begin
				r_d.data = HWDATA[7:0];
			end else if (r_q.ph_ofs == tws_pkg::OFS_IEN) begin
				r_d.ien = HWDATA[0];
			end
		end

		// Serial engine
		if (!active) begin
			r_d.st     = tws_pkg::ST_IDLE;
			r_d.sda_oe = 1'b0;
			r_d.scl_oe = 1'b0;
			r_d.busy   = 1'b0;
		end else if (start_det) begin
			r_d.busy   = 1'b1;
			r_d.match  = 1'b0;
			r_d.st     = tws_pkg::ST_ADDR;
			r_d.cnt    = 3'h0;
			r_d.sda_oe = 1'b0;
			r_d.scl_oe = 1'b0;
		end else if (stop_det) begin
			r_d.busy   = 1'b0;
			r_d.st     = tws_pkg::ST_IDLE;
			r_d.sda_oe = 1'b0;
			r_d.scl_oe = 1'b0;
		end else begin
			case (r_q.st)
				tws_pkg::ST_ADDR: begin
					if (scl_rise) begin
						r_d.shreg = {r_q.shreg[6:0], sda};
						r_d.cnt   = r_q.cnt + 3'h1;
						if (r_q.cnt == tws_pkg::LAST_BIT) begin
							if (r_q.shreg[6:0] == r_q.own_addr) begin
								r_d.match   = 1'b1;
								r_d.rw      = sda;
								r_d.transmit_select_bit = sda;
								r_d.pend    = 1'b1;
								r_d.ack_drv = 1'b1;
								r_d.st      = tws_pkg::ST_ACK_SET;
							end else begin
								r_d.st = tws_pkg::ST_IGNORE;
							end
						end
					end
				end
				tws_pkg::ST_ACK_SET: begin
					if (scl_fall) begin
						r_d.sda_oe = r_q.ack_drv;
						r_d.st     = tws_pkg::ST_ACK_END;
					end
				end
				tws_pkg::ST_ACK_END: begin
					if (scl_fall) begin
						r_d.sda_oe = 1'b0;
						r_d.scl_oe = 1'b1;
						r_d.st     = tws_pkg::ST_STRETCH;
					end
				end
				tws_pkg::ST_STRETCH: begin
					if (r_q.transmit_select_bit & data_wr) begin
						// load byte, MSB out first
						// Clock stays held one more cycle so the MSB is set up first
						r_d.shreg          = HWDATA[7:0];
						r_d.sda_oe         = ~HWDATA[7];
						r_d.cnt            = 3'h0;
						r_d.byte_done_flag = 1'b0;
						r_d.st             = tws_pkg::ST_TX;
					end else if (~r_q.transmit_select_bit & data_rd) begin
						r_d.scl_oe         = 1'b0;
						r_d.cnt            = 3'h0;
						r_d.byte_done_flag = 1'b0;
						r_d.st             = tws_pkg::ST_RX;
					end
				end
				tws_pkg::ST_RX: begin
					r_d.byte_done_flag = 1'b0;
					if (scl_rise) begin
						r_d.shreg = {r_q.shreg[6:0], sda};
						r_d.cnt   = r_q.cnt + 3'h1;
						if (r_q.cnt == tws_pkg::LAST_BIT) begin
							r_d.data    = {r_q.shreg[6:0], sda};
							r_d.byte_done_flag = 1'b1;
							r_d.pend    = 1'b1;
							r_d.match   = 1'b0;
							r_d.ack_drv = ~r_q.ack_to_send_bit;
							r_d.st      = tws_pkg::ST_ACK_SET;
						end
					end
				end
				tws_pkg::ST_TX: begin
					r_d.byte_done_flag = 1'b0;
					// Let the stretched clock go once the MSB stands
					r_d.scl_oe         = 1'b0;
					if (scl_fall) begin
						r_d.shreg  = {r_q.shreg[6:0], 1'b0};
						r_d.sda_oe = ~r_q.shreg[6];
					end
					if (scl_rise) begin
						r_d.cnt = r_q.cnt + 3'h1;
						if (r_q.cnt == tws_pkg::LAST_BIT) begin
							r_d.st = tws_pkg::ST_TX_REL;
						end
					end
				end
				tws_pkg::ST_TX_REL: begin
					// Free SDA for the master's acknowledge
					if (scl_fall) begin
						r_d.sda_oe = 1'b0;
						r_d.st     = tws_pkg::ST_TX_CHK;
					end
				end
				tws_pkg::ST_TX_CHK: begin
					if (scl_rise) begin
						r_d.ack_received_flag = sda;
						r_d.byte_done_flag    = 1'b1;
						r_d.pend  = 1'b1;
						r_d.match = 1'b0;
						r_d.st    = tws_pkg::ST_TX_END;
					end
				end
				tws_pkg::ST_TX_END: begin
					if (scl_fall) begin
						if (r_q.ack_received_flag) begin
							r_d.st = tws_pkg::ST_IGNORE;
						end else begin
							r_d.scl_oe = 1'b1;
							r_d.st     = tws_pkg::ST_STRETCH;
						end
					end
				end
				default: begin
					// Idle and ignore leave the pins released
					r_d.sda_oe = 1'b0;
					r_d.scl_oe = 1'b0;
				end
			endcase
		end

		r_d.irq = r_d.pend & r_q.ien;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge CLK) begin
		if (RST) begin
			r_q          <= '0;
			r_q.st       <= tws_pkg::ST_IDLE;
			r_q.mode     <= tws_pkg::RST_MODE;
			r_q.own_addr <= tws_pkg::RST_ADDR;
			r_q.data     <= tws_pkg::RST_DATA;
		end else begin
			r_q <= r_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// only pulls low, never makes START
	assign SDA_O     = 1'b0;
	assign SCL_O     = 1'b0;
	assign SDA_OE    = r_q.sda_oe;
	assign SCL_OE    = r_q.scl_oe;
	assign IRQ       = r_q.irq;
	assign HRDATA    = r_q.hrdata;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	// Size is ignored: every access is a whole word
	logic unused_ok;
	assign unused_ok = ^{HSIZE, HADDR[31:8], HTRANS[0]};

endmodule

/* File: test/tws_checker.sv */
// Checker for the two-wire slave, bound to every tws_slave.
// Assumes one AHB master and pulled-up bus wires.
`timescale 1ns/1ns
module tws_checker (
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RST,
	// Register bus
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	// Pins and request
	input wire logic        SCL_I,
	input wire logic        SCL_OE,
	input wire logic        SDA_OE,
	input wire logic        IRQ
);
	logic       take;
	logic       dacc;
	logic       wr_q;
	logic       ien_q;
	logic       act_q;
	logic [7:0] ofs_q;

	assign take = HSEL && HTRANS[1] && HREADY;
	assign dacc = take && HADDR[7:0] == tws_pkg::OFS_DATA;

	// Shadows land with the data phase, as the block's registers do
	always_ff @(posedge CLK) begin
		if (RST) begin
			wr_q  <= 1'b0;
			ien_q <= 1'b0;
			act_q <= 1'b0;
			ofs_q <= 8'h00;
		end else begin
			wr_q <= take && HWRITE;
			if (take)
				ofs_q <= HADDR[7:0];
			if (wr_q && ofs_q == tws_pkg::OFS_IEN)
				ien_q <= HWDATA[0];
			if (wr_q && ofs_q == tws_pkg::OFS_CTL0)
				act_q <= HWDATA[tws_pkg::BIT_EN]
					&& HWDATA[tws_pkg::POS_MODE +: 3] == tws_pkg::MODE_TWO_WIRE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	chk_reset_quiet: assert property ($fell(RST) |-> !SDA_OE && !SCL_OE && !IRQ && HRDATA == 32'h0)
		else $error("outputs not quiet after reset");
	chk_bus_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus wait or error seen");
	chk_irq_mask: assert property (!ien_q [*2] |-> !IRQ)
		else $error("request out while disabled");
	chk_float_off: assert property (!act_q [*3] |-> !SDA_OE && !SCL_OE)
		else $error("pin pulled while off");
	chk_stretch_hold: assert property (SCL_OE && act_q && !dacc && !$past(dacc)
		&& !$past(dacc, 2) |=> SCL_OE)
		else $error("stretch dropped early");
	chk_stretch_free: assert property (dacc && SCL_OE |-> ##[1:3] !SCL_OE)
		else $error("stretch kept after access");
	chk_sda_scl_low: assert property ($changed(SDA_OE) || $rose(SCL_OE) |-> !SCL_I)
		else $error("pin changed while clock high");
	chk_rdata_hold: assert property (!(take && !HWRITE) |=> $stable(HRDATA))
		else $error("read data moved");

	cov_stretch: cover property ($fell(SCL_OE));
	cov_irq: cover property ($rose(IRQ));
	cov_ack: cover property ($rose(SDA_OE));
endmodule

bind tws_slave tws_checker chk (
	.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY, .HRDATA,
	.HREADYOUT, .HRESP, .SCL_I, .SCL_OE, .SDA_OE, .IRQ
);

/* File: test/tws_master_model.sv */
// Behavioural two-wire bus master, open-drain on both wires.
// Assumes the testbench resolves the wires with pull-ups.
`timescale 1ns/1ns
module tws_master_model (
	// Resolved wire levels
	input  wire logic scl,
	input  wire logic sda,
	// Pull-low enables
	output logic      scl_oe,
	output logic      sda_oe
);
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// One 800 ns bit; a stretched low is waited out, but not forever
	task automatic bit_x(input logic b, output logic r);
		int n;
		n = 0;
		scl_oe = 1'b1;
		#100 sda_oe = !b;
		#300 scl_oe = 1'b0;
		while (scl !== 1'b1 && n < 500) begin
			#20 n++;
		end
		if (n == 500)
			testbench.tmo();
		#200 r = sda;
		#200;
	endtask

	task automatic start();
		sda_oe = 1'b1;
		#400 scl_oe = 1'b1;
	endtask

	// Data low, clock up, then data released
	task automatic stop();
		logic r;
		bit_x(1'b0, r);
		sda_oe = 1'b0;
		#400;
	endtask

	task automatic byte_x(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ao);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(ai, ao);
	endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench: AHB master tasks, two-wire master model, checker.
// Assumes the package, the slave and the checker are compiled first.
`timescale 1ns/1ns
module testbench;
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic        HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0]  HTRANS = 2'h0;
	logic        HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0;
	logic [31:0] HRDATA;
	logic        HREADYOUT, SCL_OE, SDA_OE, IRQ;
	logic        SCL_O, SDA_O, HRESP;
	logic        m_scl, m_sda, scl, sda, ak;
	logic [31:0] d;
	logic [7:0]  q;
	int          err_count = 0;
	int          num_checks = 0;

	always #50 CLK = !CLK;
	assign scl = !(m_scl || SCL_OE);
	assign sda = !(m_sda || SDA_OE);

	tws_slave dut (
		.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
		.HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .SCL_I(scl), .SCL_O,
		.SCL_OE, .SDA_I(sda), .SDA_O, .SDA_OE, .IRQ
	);
	tws_master_model m (.scl, .sda, .scl_oe(m_scl), .sda_oe(m_sda));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tmo();
		err_count++;
		stop_test();
	endtask
	task automatic rdy();
		int n;
		n = 0;
		@(posedge CLK);
		while (HREADYOUT !== 1'b1) begin
			if (++n > 20)
				tmo();
			@(posedge CLK);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge CLK);
		HSEL   <= 1'b1;
		HADDR  <= {24'h0, a};
		HTRANS <= 2'h2;
		HWRITE <= w;
		rdy();
		HTRANS <= 2'h0;
		HWDATA <= wd;
		rdy();
		d = HRDATA;
	endtask
	task automatic c1(input int b, input logic e, input string nm);
		bus(1'b0, tws_pkg::OFS_CTL1, 32'h0);
		chk(nm, e, d[b]);
	endtask
	// Software side of a stretch: see it held, then touch the data register
	task automatic rel(input logic w, input logic [7:0] wd);
		int n;
		n = 0;
		while (SCL_OE !== 1'b1) begin
			if (++n > 200)
				tmo();
			@(posedge CLK);
		end
		repeat (4) @(posedge CLK);
		chk("stretch", 1, SCL_OE);
		bus(w, tws_pkg::OFS_DATA, {24'h0, wd});
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] ofs [6];
		ofs = '{tws_pkg::OFS_CTL0, tws_pkg::OFS_CTL1, tws_pkg::OFS_ADDR, tws_pkg::OFS_DATA,
			tws_pkg::OFS_IEN, 8'h20};
		bus(1'b1, 8'h20, 32'hff);
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], 32'h0);
			chk("reset value", 32'h0, d);
		end
		bus(1'b1, tws_pkg::OFS_ADDR, {24'h0, 7'h5a, 1'b0});
		bus(1'b1, tws_pkg::OFS_IEN, 32'h1);
		bus(1'b1, tws_pkg::OFS_CTL0, {28'h0, tws_pkg::MODE_TWO_WIRE, 1'b1});
		bus(1'b0, tws_pkg::OFS_ADDR, 32'h0);
		chk("own addr", {24'h0, 7'h5a, 1'b0}, d);
		chk("okay resp", 0, HRESP);
		$display("test regs done");
	endtask
	task automatic t_rx();
		m.start();
		c1(tws_pkg::BIT_BUSY, 1, "busy");
		m.byte_x({7'h5a, 1'b0}, 1'b1, q, ak);
		chk("addr ack", 0, ak);
		c1(tws_pkg::BIT_MATCH, 1, "match");
		c1(tws_pkg::BIT_RW, 0, "rw");
		c1(tws_pkg::BIT_TRANSMIT_SELECT, 0, "tx select");
		chk("irq", 1, IRQ);
		bus(1'b1, tws_pkg::OFS_IEN, 32'h0);
		repeat (2) @(posedge CLK);
		chk("irq masked", 0, IRQ);
		bus(1'b1, tws_pkg::OFS_IEN, 32'h1);
		bus(1'b1, tws_pkg::OFS_CTL1, 32'h1);
		repeat (2) @(posedge CLK);
		chk("irq cleared", 0, IRQ);
		fork
			m.byte_x(8'hc3, 1'b1, q, ak);
			rel(1'b0, 8'h0);
		join
		chk("data ack", 0, ak);
		chk("irq byte", 1, IRQ);
		c1(tws_pkg::BIT_BYTE_DONE, 1, "byte done");
		c1(tws_pkg::BIT_MATCH, 0, "match byte");
		bus(1'b1, tws_pkg::OFS_CTL1, 32'h1 | (32'h1 << tws_pkg::BIT_ACK_TO_SEND));
		fork
			m.byte_x(8'h3c, 1'b1, q, ak);
			rel(1'b0, 8'h0);
		join
		chk("rx data", 8'hc3, d);
		chk("data nack", 1, ak);
		fork
			m.stop();
			rel(1'b0, 8'h0);
		join
		chk("rx data2", 8'h3c, d);
		c1(tws_pkg::BIT_BUSY, 0, "free");
		$display("test rx done");
	endtask
	task automatic t_tx();
		m.start();
		m.byte_x({7'h5a, 1'b1}, 1'b1, q, ak);
		chk("addr ack", 0, ak);
		c1(tws_pkg::BIT_RW, 1, "rw");
		c1(tws_pkg::BIT_TRANSMIT_SELECT, 1, "tx select");
		fork
			m.byte_x(8'hff, 1'b0, q, ak);
			rel(1'b1, 8'ha5);
		join
		chk("tx data", 8'ha5, q);
		c1(tws_pkg::BIT_ACK_RECEIVED, 0, "ack in");
		fork
			m.byte_x(8'hff, 1'b1, q, ak);
			rel(1'b1, 8'h69);
		join
		chk("tx data2", 8'h69, q);
		c1(tws_pkg::BIT_ACK_RECEIVED, 1, "ack in");
		m.stop();
		chk("sda free", 0, SDA_OE);
		chk("pins low", 0, {SCL_O, SDA_O});
		$display("test tx done");
	endtask
	task automatic t_other();
		m.start();
		m.byte_x({7'h11, 1'b0}, 1'b1, q, ak);
		chk("other nack", 1, ak);
		m.stop();
		c1(tws_pkg::BIT_MATCH, 0, "no match");
		bus(1'b1, tws_pkg::OFS_CTL0, {28'h0, 3'h5, 1'b1});
		m.start();
		m.byte_x({7'h5a, 1'b0}, 1'b1, q, ak);
		chk("wrong mode", 1, ak);
		m.stop();
		$display("test other done");
	endtask

	initial begin
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		t_regs();
		t_rx();
		t_tx();
		t_other();
		stop_test();
	end
endmodule
